//--- src/aps_pkg.sv
// package: register map, field layout and pin control carrier
package aps_pkg;
   localparam int APS_ADDR_W = 4;
   localparam int APS_DATA_W = 8;
   localparam int APS_NUM_REGS = 3;
   localparam int APS_NUM_PINS = APS_NUM_REGS * APS_DATA_W;
   localparam logic [APS_ADDR_W-1:0] APS_OFS_LOW = 4'h0;
   localparam logic [APS_ADDR_W-1:0] APS_OFS_MID = 4'h1;
   localparam logic [APS_ADDR_W-1:0] APS_OFS_HIGH = 4'h2;
   localparam int APS_LOW_BASE = 0;
   localparam int APS_MID_BASE = 8;
   localparam int APS_HIGH_BASE = 16;
   localparam logic [APS_DATA_W-1:0] APS_SEL_RESET = 8'h00;
   localparam logic [APS_DATA_W-1:0] APS_UNMAPPED_READ = 8'h00;

   typedef struct packed {
      logic [APS_ADDR_W-1:0] addr;
      logic [APS_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } aps_req_t;

   // per-pin overrides toward the port logic
   typedef struct packed {
      logic [APS_NUM_PINS-1:0] out_hiz;
      logic [APS_NUM_PINS-1:0] in_off;
      logic [APS_NUM_PINS-1:0] pull_off;
   } aps_pin_ctl_t;
endpackage

//--- src/aps_pin_select.sv
// analog pin select registers and per-pin port override logic
`timescale 1ns/1ns
`default_nettype none
module aps_pin_select #(
   // register count and width per register
   parameter int NUM_REGS = aps_pkg::APS_NUM_REGS,
   parameter int DATA_W = aps_pkg::APS_DATA_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire aps_pkg::aps_req_t req,
   output logic [aps_pkg::APS_DATA_W-1:0] rdata,
   // port logic side, per pin
   input wire logic [aps_pkg::APS_NUM_PINS-1:0] port_oe,
   input wire logic [aps_pkg::APS_NUM_PINS-1:0] port_in,
   input wire logic [aps_pkg::APS_NUM_PINS-1:0] port_pull_en,
   output logic [aps_pkg::APS_NUM_PINS-1:0] pin_oe,
   output logic [aps_pkg::APS_NUM_PINS-1:0] port_read,
   output logic [aps_pkg::APS_NUM_PINS-1:0] pin_pull_en,
   output aps_pkg::aps_pin_ctl_t pin_ctl
);
   import aps_pkg::*;

   // the pin map is fixed at three 8-bit registers
   if (NUM_REGS != APS_NUM_REGS || DATA_W != APS_DATA_W) begin : g_bad_size
      $error("register count or width does not fit the pin map");
   end

   logic [APS_DATA_W-1:0] sel_low_r, sel_mid_r, sel_high_r;
   logic [APS_DATA_W-1:0] rdata_r, rdata_nxt;
   wire logic hit_low = req.addr == APS_OFS_LOW;
   wire logic hit_mid = req.addr == APS_OFS_MID;
   wire logic hit_high = req.addr == APS_OFS_HIGH;
   wire logic wr_low = req.wr && hit_low;
   wire logic wr_mid = req.wr && hit_mid;
   wire logic wr_high = req.wr && hit_high;
   wire logic [APS_NUM_PINS-1:0] sel_all;

   // channel order: low holds 0-7, mid 8-15, high 16-23
   assign sel_all[APS_LOW_BASE +: APS_DATA_W] = sel_low_r;
   assign sel_all[APS_MID_BASE +: APS_DATA_W] = sel_mid_r;
   assign sel_all[APS_HIGH_BASE +: APS_DATA_W] = sel_high_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         sel_low_r <= APS_SEL_RESET;
         sel_mid_r <= APS_SEL_RESET;
         sel_high_r <= APS_SEL_RESET;
         rdata_r <= APS_UNMAPPED_READ;
      end else begin
         if (wr_low) sel_low_r <= req.wdata;
         if (wr_mid) sel_mid_r <= req.wdata;
         if (wr_high) sel_high_r <= req.wdata;
         rdata_r <= rdata_nxt;
      end
   end

   // read data stands only in the cycle after the strobe
   assign rdata_nxt = !req.rd ? APS_UNMAPPED_READ :
                      hit_low ? sel_low_r :
                      hit_mid ? sel_mid_r :
                      hit_high ? sel_high_r : APS_UNMAPPED_READ;
   assign rdata = rdata_r;

   genvar i;
   generate
      for (i = 0; i < APS_NUM_PINS; i++) begin : g_pin
         // selected pin: no drive, no input, no pull-up
         assign pin_oe[i] = port_oe[i] && !sel_all[i];
         assign port_read[i] = port_in[i] && !sel_all[i];
         assign pin_pull_en[i] = port_pull_en[i] && !sel_all[i];
      end
   endgenerate

   assign pin_ctl.out_hiz = sel_all;
   assign pin_ctl.in_off = sel_all;
   assign pin_ctl.pull_off = sel_all;

   // assertions: reset and register writes
   sel_reset_a: assert property (
      @(posedge clk)
      reset
      |=> sel_all == '0)
      else $error("select bits not cleared by reset");

   reset_read_a: assert property (
      @(posedge clk)
      reset
      |=> rdata == APS_UNMAPPED_READ)
      else $error("read data not cleared by reset");

   reset_pass_a: assert property (
      @(posedge clk)
      reset
      |=> pin_oe == port_oe && port_read == port_in && pin_pull_en == port_pull_en)
      else $error("port signals not passed through after reset");

   low_write_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_low
      |=> sel_all[7:0] == $past(req.wdata))
      else $error("low register not mapped to channels 0-7");

   mid_write_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_mid
      |=> sel_all[15:8] == $past(req.wdata))
      else $error("mid register not mapped to channels 8-15");

   high_write_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_high
      |=> sel_all[23:16] == $past(req.wdata))
      else $error("high register not mapped to channels 16-23");

   low_keep_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_low
      |=> $stable(sel_all[23:8]))
      else $error("low register write disturbed other bits");

   mid_keep_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_mid
      |=> $stable(sel_all[23:16]) && $stable(sel_all[7:0]))
      else $error("mid register write disturbed other bits");

   high_keep_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_high
      |=> $stable(sel_all[15:0]))
      else $error("high register write disturbed other bits");

   select_hold_a: assert property (
      @(posedge clk) disable iff (reset)
      !req.wr
      |=> $stable(sel_all))
      else $error("select bits changed without a write");

   stray_write_a: assert property (
      @(posedge clk) disable iff (reset)
      req.wr && !(hit_low || hit_mid || hit_high)
      |=> $stable(sel_all))
      else $error("unmapped write changed select bits");

   // reads
   low_read_a: assert property (
      @(posedge clk) disable iff (reset)
      req.rd && hit_low
      |=> rdata == $past(sel_low_r))
      else $error("low register read wrong");

   mid_read_a: assert property (
      @(posedge clk) disable iff (reset)
      req.rd && hit_mid
      |=> rdata == $past(sel_mid_r))
      else $error("mid register read wrong");

   high_read_a: assert property (
      @(posedge clk) disable iff (reset)
      req.rd && hit_high
      |=> rdata == $past(sel_high_r))
      else $error("high register read wrong");

   stray_read_a: assert property (
      @(posedge clk) disable iff (reset)
      req.rd && !(hit_low || hit_mid || hit_high)
      |=> rdata == APS_UNMAPPED_READ)
      else $error("unmapped read not zero");

   idle_read_a: assert property (
      @(posedge clk) disable iff (reset)
      !req.rd
      |=> rdata == APS_UNMAPPED_READ)
      else $error("read data outside read cycle");

   low_write_read_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_low ##1 (req.rd && hit_low)
      |=> rdata == $past(req.wdata, 2))
      else $error("low read after write stale");

   mid_write_read_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_mid ##1 (req.rd && hit_mid)
      |=> rdata == $past(req.wdata, 2))
      else $error("mid read after write stale");

   high_write_read_a: assert property (
      @(posedge clk) disable iff (reset)
      wr_high ##1 (req.rd && hit_high)
      |=> rdata == $past(req.wdata, 2))
      else $error("high read after write stale");

   // overrides toward the port logic
   drive_off_a: assert property (
      @(posedge clk) disable iff (reset)
      (sel_all & pin_oe) == '0)
      else $error("selected pin still driven");

   input_off_a: assert property (
      @(posedge clk) disable iff (reset)
      (sel_all & port_read) == '0)
      else $error("selected pin reads nonzero");

   pull_off_a: assert property (
      @(posedge clk) disable iff (reset)
      (sel_all & pin_pull_en) == '0)
      else $error("selected pin pull-up on");

   drive_pass_a: assert property (
      @(posedge clk) disable iff (reset)
      (~sel_all & (pin_oe ^ port_oe)) == '0)
      else $error("unselected pin drive altered");

   read_pass_a: assert property (
      @(posedge clk) disable iff (reset)
      (~sel_all & (port_read ^ port_in)) == '0)
      else $error("unselected pin read altered");

   pull_pass_a: assert property (
      @(posedge clk) disable iff (reset)
      (~sel_all & (pin_pull_en ^ port_pull_en)) == '0)
      else $error("unselected pin pull-up altered");

   ctl_hiz_a: assert property (
      @(posedge clk) disable iff (reset)
      (pin_ctl.out_hiz ^ sel_all) == '0)
      else $error("high impedance control wrong");

   ctl_input_a: assert property (
      @(posedge clk) disable iff (reset)
      (pin_ctl.in_off ^ sel_all) == '0)
      else $error("input buffer control wrong");

   ctl_pull_a: assert property (
      @(posedge clk) disable iff (reset)
      (pin_ctl.pull_off ^ sel_all) == '0)
      else $error("pull-up control wrong");

   genvar j;
   generate
      for (j = 0; j < APS_NUM_PINS; j++) begin : g_pin_chk
         taken_drive_a: assert property (
            @(posedge clk) disable iff (reset)
            sel_all[j]
            |-> !pin_oe[j])
            else $error("taken pin still driven");

         taken_read_a: assert property (
            @(posedge clk) disable iff (reset)
            sel_all[j]
            |-> !port_read[j])
            else $error("taken pin still read");

         taken_pull_a: assert property (
            @(posedge clk) disable iff (reset)
            sel_all[j]
            |-> !pin_pull_en[j])
            else $error("taken pin still pulled up");

         free_drive_a: assert property (
            @(posedge clk) disable iff (reset)
            !sel_all[j]
            |-> pin_oe[j] == port_oe[j])
            else $error("free pin drive altered");

         free_read_a: assert property (
            @(posedge clk) disable iff (reset)
            !sel_all[j]
            |-> port_read[j] == port_in[j])
            else $error("free pin read altered");

         free_pull_a: assert property (
            @(posedge clk) disable iff (reset)
            !sel_all[j]
            |-> pin_pull_en[j] == port_pull_en[j])
            else $error("free pin pull-up altered");
      end
   endgenerate

   // main scenarios
   low_set_c: cover property (
      @(posedge clk) wr_low && req.wdata != '0);
   high_set_c: cover property (
      @(posedge clk) wr_high ##1 req.rd && hit_high);
   all_sel_c: cover property (
      @(posedge clk) &sel_all);
   clear_c: cover property (
      @(posedge clk) sel_all != '0 ##1 sel_all == '0);
   stray_write_c: cover property (
      @(posedge clk) req.wr && !(hit_low || hit_mid || hit_high));
endmodule
`default_nettype wire

//--- bench/aps_pin_select_bench.sv
// bench: pin select registers and per-pin port overrides
`timescale 1ns/1ns
`default_nettype none
module aps_pin_select_bench;
   import aps_pkg::*;
   logic clk = 0, reset = 1, rd_d = 0;
   aps_req_t req = '0;
   logic [7:0] rdata, m [3] = '{default: 8'h00}, q [$];
   logic [23:0] lf = 24'h000026, oe = '0, pin = '0, pu = '0;
   logic [23:0] p_oe, p_rd, p_pu, sel;
   aps_pin_ctl_t ctl;
   int n_fail = 0, n_tests = 0, cyc = 0;
   always #5 clk = ~clk;
   aps_pin_select u_aps_pin_select (.clk(clk), .reset(reset), .req(req),
      .rdata(rdata), .port_oe(oe), .port_in(pin), .port_pull_en(pu),
      .pin_oe(p_oe), .port_read(p_rd), .pin_pull_en(p_pu), .pin_ctl(ctl));
   function automatic logic [23:0] lfsr(logic [23:0] v);
      return {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
   endfunction
   task automatic cmp(logic [23:0] got, logic [23:0] exp, string s);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %0t %s", $time, s);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one bus cycle, fresh random port inputs beside it
   task automatic op(logic w, logic r, logic [3:0] a, logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      lf = lfsr(lf);
      oe <= lf;
      pin <= {lf[11:0], lf[23:12]};
      pu <= ~lf;
      if (r) q.push_back(a < 3 ? m[a] : 8'h00);
      @(posedge clk);
      if (w && a < 3) m[a] = d;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rd_d <= req.rd;
      if (cyc > 1) cmp(rdata, rd_d ? q.pop_front() : 8'h00, "rdata");
      if (cyc == 200) begin
         n_fail++;
         test_done();
      end
   end
   always @(negedge clk) begin
      sel = {m[2], m[1], m[0]};
      if (cyc > 0) begin
         cmp(p_oe, oe & ~sel, "pin_oe");
         cmp(p_rd, pin & ~sel, "port_read");
         cmp(p_pu, pu & ~sel, "pin_pull_en");
         cmp(ctl.out_hiz, sel, "out_hiz");
         cmp(ctl.in_off, sel, "in_off");
         cmp(ctl.pull_off, sel, "pull_off");
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      reset <= 0;
      for (int a = 0; a < 4; a++) op(0, 1, a[3:0], 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 16; i++) begin
         op(1, 0, (i % 4 == 3) ? 4'hf : 4'(i % 4), i < 3 ? 8'hff : lf[7:0]);
         op(0, 1, (i % 4 == 3) ? 4'hf : 4'(i % 4), 8'h00);
      end
      op(0, 0, 4'h0, 8'h00);
      $display("test select and override done");
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule
`default_nettype wire
